// File: hdl/l2_write_and_locked_handler.sv
/*
  Secondary cache handling of processor writes, copybacks and locked pairs.
  Holds line states, tags, inclusion bits and line data for a small cache.
  Assumes one processor request at a time and a system bus that answers
  every request with sys_done, beats being marked by sys_beat_valid.
*/
`timescale 1ns/1ps
// Operation
// - Write-through hit: write line and system, state unchanged.
// - Write-through miss: no allocation, write system only.
// - Neither inhibit nor write-through: use write-back here.
// - Write-back miss: intent-to-modify fill, merge, exclusive-modified.
// - Write-back shared hit: system invalidate first, then modified.
// - Write-back exclusive hit: update, modified, no system access.
// - Inhibited write not cached, single-beat system write.
// - Inhibited write hit: copyback if modified, invalidate, then write.
// - Burst write stored critical-word-first, never sent to system.
// - Snoop copyback clears inclusion bit.
// - Replacement copyback keeps inclusion bit.
// - Flush copyback keeps inclusion bit.
// - Locked pair starting with write or inhibited read is inhibited.
// - Second half of inhibited pair passes to system as miss.
// - Locked cacheable read hit: invalidate if shared, mark modified.
// - Locked cacheable read miss: allocate and fill normally.
// - Locked write updates line; write-through adds locked system write.
// - Hold line between cacheable locked halves, retry colliding snoops.
// - Fills use strap-selected critical- or zero-word-first order.
module l2_write_and_locked_handler
  import l2wr_pkg::*;
#(
  parameter int LINES = 1 << IDX_W
)(
  // Clock, reset and strap
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              fill_zero_first,
  // Processor request
  input  wire logic              proc_req,
  input  wire logic [ADDR_W-1:0] proc_addr,
  input  wire logic              proc_write,
  input  wire logic              proc_burst,
  input  wire logic              proc_cache_inhibit,
  input  wire logic              proc_write_through,
  input  wire logic              proc_lock,
  input  wire cb_kind_t          proc_cb_kind,
  input  wire logic [DATA_W-1:0] proc_wdata,
  input  wire logic              proc_beat_valid,
  output logic                   proc_ready,
  output logic                   proc_ta,
  output logic      [DATA_W-1:0] proc_rdata,
  // System bus
  output logic                   sys_req,
  output sys_cmd_t               sys_cmd,
  output logic      [ADDR_W-1:0] sys_addr,
  output logic                   sys_lock,
  output logic      [DATA_W-1:0] sys_wdata,
  input  wire logic              sys_beat_valid,
  input  wire logic [DATA_W-1:0] sys_rdata,
  input  wire logic              sys_done,
  // Snooping
  input  wire logic              snoop_valid,
  input  wire logic [ADDR_W-1:0] snoop_addr,
  output logic                   snoop_retry,
  // Inclusion state
  output logic      [LINES-1:0]  primary_inclusion_tags
);

  localparam int DIDX_W = IDX_W + BEAT_W;
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  line_state_t       secondary_state_tags [LINES];
  logic [TAG_W-1:0]  line_tag [LINES];
  logic [DATA_W-1:0] line_data [LINES*4];

  fsm_t              state, next_state;
  req_t              rq, next_rq;
  logic [BEAT_W-1:0] cnt, next_cnt;
  logic              lock_ci, next_lock_ci;
  logic              lock_cache, next_lock_cache;
  logic              do_merge, next_do_merge;
  logic              need_fill, next_need_fill;
  logic              zero_first, strap_done;
  logic              next_proc_ta;
  logic [DATA_W-1:0] next_proc_rdata;
  sys_cmd_t          next_sys_cmd;
  logic [ADDR_W-1:0] next_sys_addr;
  logic              next_sys_lock;
  logic [DATA_W-1:0] next_sys_wdata;

  logic              st_we, incl_we, incl_val, d_we;
  line_state_t       st_val;
  logic [DIDX_W-1:0] d_addr;
  logic [DATA_W-1:0] d_val;

  logic [IDX_W-1:0]  idx;
  logic              hit, first_lock;
  line_state_t       cur;
  logic [BEAT_W-1:0] fill_start;

  lock_if lk ();

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic [DIDX_W-1:0] dsel(input logic [IDX_W-1:0] i, input logic [BEAT_W-1:0] b);
    return {i, b};
  endfunction

  function automatic logic [ADDR_W-1:0] line_addr(input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i,
                                                  input logic [BEAT_W-1:0] b);
    return {t, i, b, BYTE_ZERO};
  endfunction

  assign idx        = idx_of(rq.addr);
  assign cur        = secondary_state_tags[idx];
  assign hit        = (cur != LS_INVALID) && (line_tag[idx] == rq.addr[TAG_LSB +: TAG_W]);
  assign first_lock = rq.lock && !lock_ci && !lock_cache;
  assign fill_start = zero_first ? BEAT_ZERO : rq.addr[BEAT_LSB +: BEAT_W];
  assign proc_ready = (state == ST_IDLE);
  assign sys_req    = (state == ST_COPYBACK) || (state == ST_INVAL) || (state == ST_FILL) ||
                      (state == ST_SYSACC);

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zero_first <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      zero_first <= fill_zero_first;
      strap_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_rq         = rq;
    next_cnt        = cnt;
    next_lock_ci    = lock_ci;
    next_lock_cache = lock_cache;
    next_do_merge   = do_merge;
    next_need_fill  = need_fill;
    next_proc_ta    = 1'b0;
    next_proc_rdata = proc_rdata;
    next_sys_cmd    = sys_cmd;
    next_sys_addr   = sys_addr;
    next_sys_lock   = sys_lock;
    st_we    = 1'b0;
    st_val   = LS_INVALID;
    incl_we  = 1'b0;
    incl_val = 1'b0;
    d_we     = 1'b0;
    d_addr   = dsel(idx, rq.addr[BEAT_LSB +: BEAT_W]);
    d_val    = rq.wdata;
    case (state)
      ST_IDLE: begin
        if (proc_req) begin
          next_rq = '{addr: proc_addr, write: proc_write, burst: proc_burst, ci: proc_cache_inhibit,
                      wt: proc_write_through, lock: proc_lock, kind: proc_cb_kind, wdata: proc_wdata};
          next_state = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        next_do_merge  = 1'b0;
        next_need_fill = 1'b0;
        next_cnt       = BEAT_ZERO;
        next_sys_lock  = rq.lock;
        next_sys_addr  = rq.addr;
        next_sys_cmd   = rq.write ? SC_WRITE : SC_READ;
        if (rq.write && rq.burst) begin
          // Copyback beats go to the cache only
          next_state = ST_BURST;
        end else if (lock_ci) begin
          next_lock_ci = 1'b0;
          next_state   = ST_SYSACC;
        end else if (rq.ci || (first_lock && rq.write)) begin
          next_lock_ci = first_lock;
          if (hit && cur == LS_MOD) begin
            next_sys_cmd  = SC_COPYBACK;
            next_sys_lock = 1'b0;
            next_sys_addr = line_addr(line_tag[idx], idx, BEAT_ZERO);
            next_state    = ST_COPYBACK;
          end else begin
            st_we = hit;
            next_state = ST_SYSACC;
          end
        end else if (lock_cache) begin
          next_lock_cache = 1'b0;
          next_do_merge   = 1'b1;
          next_state      = rq.wt ? ST_SYSACC : ST_FINISH;
        end else if (!rq.write && !rq.lock) begin
          // Plain reads are simply passed on here
          next_state = ST_SYSACC;
        end else if (rq.wt && !rq.lock) begin
          d_we = hit;
          next_state = ST_SYSACC;
        end else begin
          next_lock_cache = first_lock;
          next_do_merge   = 1'b1;
          next_need_fill  = !hit;
          if (hit) begin
            // Shared line needs a system invalidate
            next_sys_cmd = SC_INVAL;
            next_sys_lock = 1'b0;
            next_state = (cur == LS_SHARED) ? ST_INVAL : ST_FINISH;
          end else if (cur == LS_MOD) begin
            next_sys_cmd  = SC_COPYBACK;
            next_sys_lock = 1'b0;
            next_sys_addr = line_addr(line_tag[idx], idx, BEAT_ZERO);
            next_state    = ST_COPYBACK;
          end else begin
            next_sys_cmd  = SC_RWITM;
            next_sys_lock = 1'b0;
            next_sys_addr = line_addr(rq.addr[TAG_LSB +: TAG_W], idx, fill_start);
            next_state    = ST_FILL;
          end
        end
      end
      ST_COPYBACK: begin
        if (sys_beat_valid) begin
          next_cnt = cnt + BEAT_ONE;
        end
        if (sys_done) begin
          st_we    = 1'b1;
          next_cnt = BEAT_ZERO;
          if (need_fill) begin
            next_sys_cmd  = SC_RWITM;
            next_sys_addr = line_addr(rq.addr[TAG_LSB +: TAG_W], idx, fill_start);
            next_state    = ST_FILL;
          end else begin
            next_sys_cmd  = rq.write ? SC_WRITE : SC_READ;
            next_sys_addr = rq.addr;
            next_sys_lock = rq.lock;
            next_state    = ST_SYSACC;
          end
        end
      end
      ST_INVAL: begin
        if (sys_done) begin
          next_state = ST_FINISH;
        end
      end
      ST_FILL: begin
        if (sys_beat_valid) begin
          d_we     = 1'b1;
          d_addr   = dsel(idx, fill_start + cnt);
          d_val    = sys_rdata;
          next_cnt = cnt + BEAT_ONE;
        end
        if (sys_done) begin
          st_we      = 1'b1;
          st_val     = LS_EXCL;
          next_state = ST_FINISH;
        end
      end
      ST_BURST: begin
        if (proc_beat_valid) begin
          d_we     = 1'b1;
          d_addr   = dsel(idx, rq.addr[BEAT_LSB +: BEAT_W] + cnt);
          d_val    = proc_wdata;
          next_cnt = cnt + BEAT_ONE;
          if (cnt == BEAT_LAST) begin
            st_we  = hit;
            st_val = LS_MOD;
            incl_we    = (rq.kind == CB_SNOOP);
            next_state = ST_FINISH;
          end
        end
      end
      ST_SYSACC: begin
        if (sys_done) begin
          if (!rq.write) begin
            next_proc_rdata = sys_rdata;
          end
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (do_merge) begin
          st_we  = 1'b1;
          st_val = LS_MOD;
          d_we   = rq.write;
          if (!rq.write) begin
            next_proc_rdata = line_data[d_addr];
          end
        end
        next_proc_ta = 1'b1;
        next_state   = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_sys_wdata = (next_state == ST_COPYBACK) ? line_data[dsel(idx, next_cnt)] : rq.wdata;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      rq         <= '0;
      cnt        <= BEAT_ZERO;
      lock_ci    <= 1'b0;
      lock_cache <= 1'b0;
      do_merge   <= 1'b0;
      need_fill  <= 1'b0;
      proc_ta    <= 1'b0;
      proc_rdata <= '0;
      sys_cmd    <= SC_NONE;
      sys_addr   <= '0;
      sys_lock   <= 1'b0;
      sys_wdata  <= '0;
    end else begin
      state      <= next_state;
      rq         <= next_rq;
      cnt        <= next_cnt;
      lock_ci    <= next_lock_ci;
      lock_cache <= next_lock_cache;
      do_merge   <= next_do_merge;
      need_fill  <= next_need_fill;
      proc_ta    <= next_proc_ta;
      proc_rdata <= next_proc_rdata;
      sys_cmd    <= next_sys_cmd;
      sys_addr   <= next_sys_addr;
      sys_lock   <= next_sys_lock;
      sys_wdata  <= next_sys_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Tag and inclusion arrays
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LINES; i++) begin
        secondary_state_tags[i]   <= LS_INVALID;
        line_tag[i]               <= '0;
        primary_inclusion_tags[i] <= 1'b0;
      end
    end else begin
      if (st_we) begin
        secondary_state_tags[idx] <= st_val;
        line_tag[idx]             <= rq.addr[TAG_LSB +: TAG_W];
      end
      if (incl_we) begin
        primary_inclusion_tags[idx] <= incl_val;
      end
    end
  end

  // Line data needs no reset; state gates every use
  always_ff @(posedge clk_sys) begin
    if (d_we) begin
      line_data[d_addr] <= d_val;
    end
  end

  // ----------------------------------------------------------------
  // Lock collision buffer
  // ----------------------------------------------------------------
  // Hold line across the locked pair
  assign lk.hold         = next_lock_cache && !lock_cache;
  assign lk.release_line = lock_cache && !next_lock_cache;
  assign lk.line         = rq.addr[ADDR_W-1:IDX_LSB];
  assign lk.snoop_valid  = snoop_valid;
  assign lk.snoop_line   = snoop_addr[ADDR_W-1:IDX_LSB];
  assign snoop_retry     = lk.retry;

  lock_guard u_lock_guard (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .lk      (lk.guard)
  );

endmodule

// File: include/l2wr_pkg.sv
/*
  Shared constants and types for the secondary cache write and locked-pair handler.
  Assumes a 32-bit processor address, 64-bit beats and four beats to a line.
*/
package l2wr_pkg;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 64;
  localparam int BEAT_W   = 2;
  localparam int BEAT_LSB = 3;
  localparam int IDX_LSB  = BEAT_LSB + BEAT_W;
  localparam int IDX_W    = 4;
  localparam int TAG_LSB  = IDX_LSB + IDX_W;
  localparam int TAG_W    = ADDR_W - TAG_LSB;

  localparam logic [BEAT_W-1:0]   BEAT_ZERO = 2'h0;
  localparam logic [BEAT_W-1:0]   BEAT_ONE  = 2'h1;
  localparam logic [BEAT_W-1:0]   BEAT_LAST = 2'h3;
  localparam logic [BEAT_LSB-1:0] BYTE_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LS_INVALID, LS_SHARED, LS_EXCL, LS_MOD} line_state_t;
  typedef enum logic [2:0] {SC_NONE, SC_WRITE, SC_READ, SC_INVAL, SC_RWITM, SC_COPYBACK} sys_cmd_t;
  typedef enum logic [1:0] {CB_REPLACE, CB_SNOOP, CB_FLUSH} cb_kind_t;
  typedef enum logic [2:0] {ST_IDLE, ST_LOOKUP, ST_COPYBACK, ST_INVAL, ST_FILL, ST_BURST,
                            ST_SYSACC, ST_FINISH} fsm_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              burst;
    logic              ci;
    logic              wt;
    logic              lock;
    cb_kind_t          kind;
    logic [DATA_W-1:0] wdata;
  } req_t;

endpackage

// File: include/lock_if.sv
/*
  Carrier between the handler and its lock collision buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface lock_if;
  import l2wr_pkg::*;
  logic                            hold;
  logic                            release_line;
  logic [ADDR_W-IDX_LSB-1:0]       line;
  logic                            snoop_valid;
  logic [ADDR_W-IDX_LSB-1:0]       snoop_line;
  logic                            retry;

  modport ctrl  (output hold, output release_line, output line, output snoop_valid,
                 output snoop_line, input retry);
  modport guard (input hold, input release_line, input line, input snoop_valid,
                 input snoop_line, output retry);
endinterface

// File: hdl/lock_guard.sv
/*
  Lock collision buffer: holds one line address between the halves of a
  cacheable locked pair and retries snoops to it.
  Assumes snoop addresses are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module lock_guard
  import l2wr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Control side
  lock_if.guard     lk
);

  logic                      held;
  logic                      next_held;
  logic [ADDR_W-IDX_LSB-1:0] addr;
  logic [ADDR_W-IDX_LSB-1:0] next_addr;

  // ----------------------------------------------------------------
  // Hold state
  // ----------------------------------------------------------------
  always_comb begin
    next_held = held;
    next_addr = addr;
    if (lk.release_line) begin
      next_held = 1'b0;
    end
    // Hold wins over a release in the same cycle
    if (lk.hold) begin
      next_held = 1'b1;
      next_addr = lk.line;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      held <= 1'b0;
      addr <= '0;
    end else begin
      held <= next_held;
      addr <= next_addr;
    end
  end

  assign lk.retry = held && lk.snoop_valid && (lk.snoop_line == addr);

endmodule

// File: verif/l2wr_properties.sv
/*
  Timing checks for the write and locked-pair handler.
  Assumes binding to the handler top, one clock, rst_b active low.
*/
`timescale 1ns/1ps
module l2wr_properties
  import l2wr_pkg::*;
#(
  parameter int LINES = 16
)(
  // Clock, reset, strap
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              fill_zero_first,
  // Processor side
  input wire logic              proc_req,
  input wire logic              proc_beat_valid,
  input wire logic              proc_ready,
  input wire logic              proc_ta,
  // System side
  input wire logic              sys_req,
  input wire sys_cmd_t          sys_cmd,
  input wire logic [ADDR_W-1:0] sys_addr,
  input wire logic              sys_done,
  input wire logic              snoop_valid,
  input wire logic              snoop_retry,
  input wire logic [LINES-1:0]  primary_inclusion_tags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_ta_min;
    proc_req && proc_ready |=> !proc_ta [*2];
  endproperty
  a_ta_min: assert property (p_ta_min)
    else $error("ack earlier than lookup allows");
  property p_taken;
    proc_req && proc_ready |=> !proc_ready;
  endproperty
  a_taken: assert property (p_taken)
    else $error("ready stayed high after request");
  property p_ta_clear;
    proc_ta |-> !sys_req && proc_ready;
  endproperty
  a_ta_clear: assert property (p_ta_clear)
    else $error("ack while system work pending");
  property p_sys_hold;
    sys_req && !sys_done |=> sys_req && $stable(sys_cmd) && $stable(sys_addr);
  endproperty
  a_sys_hold: assert property (p_sys_hold)
    else $error("system request dropped or changed");
  property p_cb_start;
    sys_req && sys_cmd == SC_COPYBACK |-> sys_addr[IDX_LSB-1:BEAT_LSB] == BEAT_ZERO;
  endproperty
  a_cb_start: assert property (p_cb_start)
    else $error("copyback not from beat zero");
  property p_zero_first;
    sys_req && sys_cmd == SC_RWITM && fill_zero_first |-> sys_addr[IDX_LSB-1:BEAT_LSB] == BEAT_ZERO;
  endproperty
  a_zero_first: assert property (p_zero_first)
    else $error("fill not from beat zero");
  property p_burst_local;
    proc_beat_valid |-> !sys_req;
  endproperty
  a_burst_local: assert property (p_burst_local)
    else $error("burst beat went to system bus");
  property p_retry;
    snoop_retry |-> snoop_valid;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry without snoop");
  property p_incl;
    (primary_inclusion_tags & ~$past(primary_inclusion_tags)) == '0;
  endproperty
  a_incl: assert property (p_incl)
    else $error("inclusion bit set by write path");

  c_fill: cover property (sys_req && sys_cmd == SC_RWITM && sys_done);
  c_cb: cover property (sys_req && sys_cmd == SC_COPYBACK && sys_done);
  c_retry: cover property (snoop_retry);
endmodule

bind l2_write_and_locked_handler l2wr_properties #(.LINES(LINES)) chk (.clk_sys, .rst_b, .fill_zero_first,
  .proc_req, .proc_beat_valid, .proc_ready, .proc_ta, .sys_req, .sys_cmd, .sys_addr, .sys_done,
  .snoop_valid, .snoop_retry, .primary_inclusion_tags);

// File: verif/sys_mem_model.sv
/*
  System bus memory agent facing the handler.
  Assumes sys_req held until sys_done; answers after slow cycles.
*/
`timescale 1ns/1ps
module sys_mem_model
  import l2wr_pkg::*;
(
  // Clock and latency
  input  wire logic              clk_sys,
  input  wire logic [3:0]        slow,
  // System bus
  input  wire logic              sys_req,
  input  wire sys_cmd_t          sys_cmd,
  input  wire logic [ADDR_W-1:0] sys_addr,
  input  wire logic              sys_lock,
  input  wire logic [DATA_W-1:0] sys_wdata,
  output logic                   sys_beat_valid,
  output logic      [DATA_W-1:0] sys_rdata,
  output logic                   sys_done
);
  // Command trace, newest in low nibble
  logic [31:0]       hist;
  logic [ADDR_W-1:0] last_addr;
  logic [DATA_W-1:0] last_data;
  logic              last_lock;

  initial begin
    hist = '0;
    sys_beat_valid = 1'b0;
    sys_done = 1'b0;
    sys_rdata = 64'h0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (sys_req) begin
        hist = {hist[27:0], 1'b0, sys_cmd};
        last_addr = sys_addr;
        last_data = sys_wdata;
        last_lock = sys_lock;
        repeat (slow) begin
          @(posedge clk_sys);
          #1;
        end
        if (sys_cmd == SC_RWITM || sys_cmd == SC_COPYBACK) begin
          for (int k = 0; k < 4; k++) begin
            sys_beat_valid = 1'b1;
            sys_rdata = 64'hf0 + 64'(k);
            @(posedge clk_sys);
            #1;
          end
          sys_beat_valid = 1'b0;
        end
        sys_done = 1'b1;
        @(posedge clk_sys);
        #1;
        sys_done = 1'b0;
        // Released data turns over so stale values never match
        sys_rdata = ~sys_rdata;
      end
    end
  end
endmodule

// File: verif/tb_top.sv
/*
  Self-checking bench for the write and locked-pair handler.
  Assumes the memory agent model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top
  import l2wr_pkg::*;
;
  logic              clk_sys, rst_b, fill_zero_first, proc_req, proc_write, proc_burst;
  logic              proc_cache_inhibit, proc_write_through, proc_lock, proc_beat_valid;
  logic              proc_ready, proc_ta, sys_req, sys_lock, sys_beat_valid, sys_done;
  logic              snoop_valid, snoop_retry;
  logic [3:0]        slow;
  logic [ADDR_W-1:0] proc_addr, sys_addr, snoop_addr;
  logic [DATA_W-1:0] proc_wdata, proc_rdata, sys_wdata, sys_rdata;
  logic [15:0]       primary_inclusion_tags;
  cb_kind_t          proc_cb_kind;
  sys_cmd_t          sys_cmd;
  int                n_mismatch = 0, checked = 0, cycles = 0;
  localparam logic [ADDR_W-1:0] A = 32'h0000_0038, B = 32'h0000_0050;

  l2_write_and_locked_handler #(.LINES(16)) uut (.clk_sys, .rst_b, .fill_zero_first, .proc_req,
    .proc_addr, .proc_write, .proc_burst, .proc_cache_inhibit, .proc_write_through, .proc_lock,
    .proc_cb_kind, .proc_wdata, .proc_beat_valid, .proc_ready, .proc_ta, .proc_rdata, .sys_req,
    .sys_cmd, .sys_addr, .sys_lock, .sys_wdata, .sys_beat_valid, .sys_rdata, .sys_done,
    .snoop_valid, .snoop_addr, .snoop_retry, .primary_inclusion_tags);
  sys_mem_model mem (.clk_sys, .slow, .sys_req, .sys_cmd, .sys_addr, .sys_lock, .sys_wdata,
    .sys_beat_valid, .sys_rdata, .sys_done);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Hang guard, runs need well under this
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Attributes: write, burst, inhibit, write-through, lock
  task automatic req(input logic [ADDR_W-1:0] a, input logic [4:0] at, input logic [DATA_W-1:0] d,
                     output int n);
    {proc_write, proc_burst, proc_cache_inhibit, proc_write_through, proc_lock} = at;
    proc_addr = a;
    proc_wdata = d;
    proc_req = 1'b1;
    @(posedge clk_sys);
    #1;
    proc_req = 1'b0;
    n = 0;
    if (proc_burst) begin
      @(posedge clk_sys);
      #1;
      for (int k = 0; k < 4; k++) begin
        proc_wdata = d + 64'(k);
        proc_beat_valid = 1'b1;
        @(posedge clk_sys);
        #1;
      end
      proc_beat_valid = 1'b0;
    end
    while (proc_ta !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("proc_ta", 64'h1, 64'(n < 300));
  endtask
  task automatic snp(input logic [ADDR_W-1:0] a, input logic exp);
    snoop_valid = 1'b1;
    snoop_addr = a;
    @(posedge clk_sys);
    #1;
    chk("snoop_retry", 64'(exp), 64'(snoop_retry));
    snoop_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_wb();
    int n;
    slow = 4'h3;
    mem.hist = '0;
    req(A, 5'h10, 64'h22, n);
    chk("trace", 64'h4, 64'(mem.hist));
    chk("fill start", 64'h3, 64'(mem.last_addr[4:3]));
    mem.hist = '0;
    req(A, 5'h10, 64'h22, n);
    chk("trace", 64'h0, 64'(mem.hist));
    chk("hit latency", 64'h2, 64'(n));
    $display("t_wb done");
  endtask
  task automatic t_lock();
    int n;
    mem.hist = '0;
    req(A, 5'h01, 64'h0, n);
    chk("locked data", 64'h22, proc_rdata);
    snp(A, 1'b1);
    snp(B, 1'b0);
    req(A, 5'h13, 64'h33, n);
    chk("trace", 64'h1, 64'(mem.hist));
    chk("sys_lock", 64'h1, 64'(mem.last_lock));
    chk("sys_wdata", 64'h33, mem.last_data);
    snp(A, 1'b0);
    $display("t_lock done");
  endtask
  task automatic t_wt();
    int n;
    slow = 4'h5;
    mem.hist = '0;
    req(A, 5'h12, 64'h44, n);
    chk("sys_wdata", 64'h44, mem.last_data);
    req(B, 5'h12, 64'h55, n);
    req(B, 5'h10, 64'h66, n);
    chk("trace", 64'h114, 64'(mem.hist));
    $display("t_wt done");
  endtask
  task automatic t_ci();
    int n;
    slow = 4'h0;
    mem.hist = '0;
    req(A, 5'h14, 64'h77, n);
    req(A, 5'h14, 64'h88, n);
    chk("sys_wdata", 64'h88, mem.last_data);
    req(A, 5'h10, 64'h0, n);
    chk("trace", 64'h5114, 64'(mem.hist));
    $display("t_ci done");
  endtask
  task automatic t_burst();
    int n;
    for (int k = 0; k < 3; k++) begin
      proc_cb_kind = cb_kind_t'(k);
      mem.hist = '0;
      req(B, 5'h18, 64'h100, n);
      chk("trace", 64'h0, 64'(mem.hist));
      chk("inclusion", 64'h0, 64'(primary_inclusion_tags));
    end
    req(32'h0000_0058, 5'h01, 64'h0, n);
    chk("beat order", 64'h101, proc_rdata);
    req(B, 5'h11, 64'h0, n);
    $display("t_burst done");
  endtask
  task automatic t_lock_ci();
    int n;
    mem.hist = '0;
    req(B, 5'h11, 64'h99, n);
    chk("sys_lock", 64'h1, 64'(mem.last_lock));
    req(B, 5'h01, 64'h0, n);
    chk("trace", 64'h512, 64'(mem.hist));
    $display("t_lock_ci done");
  endtask
  task automatic t_zero();
    int n;
    rst_b = 1'b0;
    fill_zero_first = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    mem.hist = '0;
    req(A, 5'h10, 64'h0, n);
    chk("trace", 64'h4, 64'(mem.hist));
    chk("fill start", 64'h0, 64'(mem.last_addr[4:3]));
    req(A | 32'h200, 5'h01, 64'h0, n);
    chk("locked fill data", 64'hf3, proc_rdata);
    req(A | 32'h200, 5'h11, 64'h0, n);
    chk("trace", 64'h454, 64'(mem.hist));
    $display("t_zero done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    {rst_b, fill_zero_first, proc_req, proc_write, proc_burst} = '0;
    {proc_cache_inhibit, proc_write_through, proc_lock, proc_beat_valid, snoop_valid} = '0;
    proc_addr = '0;
    proc_wdata = '0;
    snoop_addr = '0;
    slow = 4'h0;
    proc_cb_kind = CB_REPLACE;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    t_wb();
    t_lock();
    t_wt();
    t_ci();
    t_burst();
    t_lock_ci();
    t_zero();
    finish_test();
  end
endmodule
